// ==== rtl/suspend_resume_regs.svh ====
// Purpose: opcodes, parameter-table fields and timing counts for suspend and resume
// Assumes: core clock period given in nanoseconds
// Notes: definitions only
`ifndef SUSPEND_RESUME_REGS_SVH
`define SUSPEND_RESUME_REGS_SVH

// ****************************************
// instruction bytes and status busy bit position
// ****************************************
`define OP_ERASE_SUSPEND 8'h75
`define OP_ERASE_RESUME 8'h7a
`define OP_PROGRAM_SUSPEND 8'h85
`define OP_PROGRAM_RESUME 8'h8a
`define OP_READ_STATUS 8'h05
`define STATUS_BUSY_BIT 0

// ****************************************
// timing
// ****************************************
`define T_CORE_NS 10
`define T_SUSP_LAT_NS 40000
`define T_RESUME_GAP_NS 128000
`define SUSP_LAT_CYC (`T_SUSP_LAT_NS / `T_CORE_NS)

// ****************************************
// parameter dword fields and reset value
// ****************************************
`define PRM_SUSP_SUPPORTED 1'b0
`define PRM_ERS_LAT_UNITS 2'b10
`define PRM_ERS_LAT_COUNT 5'b00100
`define PRM_ERS_GAP_COUNT 4'b0001
`define PRM_PGM_LAT_UNITS 2'b10
`define PRM_PGM_LAT_COUNT 5'b00100
`define PRM_PGM_GAP_COUNT 4'b0001
`define PRM_RFU 1'b1
`define PRM_ERS_PROHIB 4'b1110
`define PRM_PGM_PROHIB 4'b1100
`define PRM_ERS_UNITS_POS 29
`define PRM_PGM_UNITS_POS 18
`define PRM_DWORD_RESET 32'h4418_83ec

`endif

// ==== rtl/suspend_resume_pkg.sv ====
// Purpose: types for the suspend and resume sequencer
// Assumes: nothing
// Notes: states only
package suspend_resume_pkg;

  // embedded operation states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ERASE,
    ST_ERS_WAIT,
    ST_ERS_SUSPENDED,
    ST_PROGRAM,
    ST_PGM_WAIT,
    ST_PGM_SUSPENDED
  } op_state_t;

endpackage

// ==== rtl/program_erase_suspend_resume.sv ====
// Purpose: suspend and resume control of embedded erase and page program
// Assumes: serial mode 0, opcode first, msb first; array engine on core_clk
// Notes: link logic on sclk, operation logic on core_clk
// Operation
// RULE_01: erase reaches suspended state within 40 us of accepted suspend.
// RULE_02: host waits 128 us after erase resume before next erase suspend.
// RULE_03: program reaches suspended state within 40 us of accepted suspend.
// RULE_04: host waits 128 us after program resume before next program suspend.
// RULE_05: parameter table latency units code 10b meaning 8 us.
// RULE_06: during erase suspend host starts no erase, reads not suspended sector.
// RULE_07: during program suspend host starts no erase or program, reads not page.
// RULE_08: erase suspend opcode is 75h.
// RULE_09: erase resume opcode is 7Ah.
// RULE_10: program suspend opcode is 85h.
// RULE_11: program resume opcode is 8Ah.
// RULE_12: status read 05h returns busy in bit 0, 1 busy, 0 ready.
// RULE_13: suspend without running operation, or resume without suspension, is ignored.
// RULE_14: busy reads 0 while suspended, returns to 1 on resume.
`timescale 1ns/10ps
`include "suspend_resume_regs.svh"

module program_erase_suspend_resume (
  input wire logic core_clk, // core clock, 100 MHz
  input wire logic resetn, // async reset, active low
  input wire logic sclk, // serial link clock from host
  input wire logic cs_n, // serial chip select, active low
  input wire logic si, // serial data in
  output logic so, // serial data out
  output logic so_oe, // serial data out enable, high drives
  input wire logic erase_start, // pulse, start embedded erase
  input wire logic program_start, // pulse, start page program
  input wire logic op_complete, // pulse, array engine finished
  input wire logic array_safe_pause, // array engine at a safe pause point
  output logic array_run, // array engine may advance
  output logic operation_busy_flag, // busy indication
  output logic erase_suspended, // erase held suspended
  output logic program_suspended, // page program held suspended
  output logic [31:0] param_dword12 // suspend parameter dword
);

  localparam logic [11:0] LAT_LAST = 12'(`SUSP_LAT_CYC - 1);

  // ****************************************
  // link side: opcode capture on sclk
  // ****************************************
  logic link_rst_n;
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic op_done_q;
  logic [7:0] cmd_op_q;
  logic cmd_tgl_q;
  logic rd_active_q;
  logic [7:0] stat_sh_q;
  logic so_q;
  logic busy_ls1_q;
  logic busy_ls2_q;
  logic [7:0] op_byte;

  // frame logic clears whenever chip select is high
  assign link_rst_n = resetn & ~cs_n;
  assign op_byte = {shift_q, si};

  // bit counter and opcode shifter, per frame
  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h00;
      op_done_q <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= op_byte[6:0];
      if (bit_cnt_q == 3'h7) begin
        op_done_q <= 1'b1;
      end
    end
  end

  // opcode word and event toggle survive the frame
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      cmd_op_q <= 8'h00;
      cmd_tgl_q <= 1'b0;
    end else if (!cs_n && !op_done_q && bit_cnt_q == 3'h7) begin
      cmd_op_q <= op_byte;
      cmd_tgl_q <= ~cmd_tgl_q;
    end
  end

  // busy level into the link domain
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      busy_ls1_q <= 1'b0;
      busy_ls2_q <= 1'b0;
    end else begin
      busy_ls1_q <= operation_busy_flag;
      busy_ls2_q <= busy_ls1_q;
    end
  end

  // status byte shifter, reloaded every byte while reading
  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rd_active_q <= 1'b0;
      stat_sh_q <= 8'h00;
    end else if (bit_cnt_q == 3'h7 && (rd_active_q || (!op_done_q &&
                 op_byte == `OP_READ_STATUS))) begin
      rd_active_q <= 1'b1;
      stat_sh_q <= 8'h00;
      stat_sh_q[`STATUS_BUSY_BIT] <= busy_ls2_q; // RULE_12
    end else begin
      stat_sh_q <= {stat_sh_q[6:0], 1'b0};
    end
  end

  // output bit launched on falling edge
  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      so_q <= 1'b0;
    end else begin
      so_q <= stat_sh_q[7];
    end
  end

  assign so = so_q;
  assign so_oe = rd_active_q & ~cs_n;

  // ****************************************
  // core side: command crossing
  // ****************************************
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;
  logic cmd_valid;
  logic [7:0] cmd_op;

  // toggle synchroniser, opcode word stable while it settles
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else begin
      tgl_s1_q <= cmd_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  assign cmd_valid = tgl_s2_q ^ tgl_s3_q;
  assign cmd_op = cmd_valid ? cmd_op_q : 8'h00;

  // ****************************************
  // core side: operation sequencer
  // ****************************************
  suspend_resume_pkg::op_state_t state_q;
  suspend_resume_pkg::op_state_t state_d;
  logic [11:0] susp_cnt_q;
  logic busy_q;
  logic lat_done;

  assign lat_done = array_safe_pause || (susp_cnt_q == LAT_LAST);

  // next state; unmatched commands fall through unchanged
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      suspend_resume_pkg::ST_IDLE: begin
        if (erase_start) begin
          state_d = suspend_resume_pkg::ST_ERASE;
        end else if (program_start) begin
          state_d = suspend_resume_pkg::ST_PROGRAM;
        end
      end
      suspend_resume_pkg::ST_ERASE: begin
        if (op_complete) begin
          state_d = suspend_resume_pkg::ST_IDLE;
        end else if (cmd_op == `OP_ERASE_SUSPEND) begin // RULE_08 RULE_13
          state_d = suspend_resume_pkg::ST_ERS_WAIT;
        end
      end
      suspend_resume_pkg::ST_ERS_WAIT: begin
        if (op_complete) begin
          state_d = suspend_resume_pkg::ST_IDLE;
        end else if (lat_done) begin // RULE_01
          state_d = suspend_resume_pkg::ST_ERS_SUSPENDED;
        end
      end
      suspend_resume_pkg::ST_ERS_SUSPENDED: begin
        if (cmd_op == `OP_ERASE_RESUME) begin // RULE_09 RULE_13
          state_d = suspend_resume_pkg::ST_ERASE;
        end
      end
      suspend_resume_pkg::ST_PROGRAM: begin
        if (op_complete) begin
          state_d = suspend_resume_pkg::ST_IDLE;
        end else if (cmd_op == `OP_PROGRAM_SUSPEND) begin // RULE_10 RULE_13
          state_d = suspend_resume_pkg::ST_PGM_WAIT;
        end
      end
      suspend_resume_pkg::ST_PGM_WAIT: begin
        if (op_complete) begin
          state_d = suspend_resume_pkg::ST_IDLE;
        end else if (lat_done) begin // RULE_03
          state_d = suspend_resume_pkg::ST_PGM_SUSPENDED;
        end
      end
      suspend_resume_pkg::ST_PGM_SUSPENDED: begin
        if (cmd_op == `OP_PROGRAM_RESUME) begin // RULE_11 RULE_13
          state_d = suspend_resume_pkg::ST_PROGRAM;
        end
      end
      default: begin
        state_d = suspend_resume_pkg::ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= suspend_resume_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // suspend latency counter, runs only while pausing
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      susp_cnt_q <= 12'h000;
    end else if (state_q == suspend_resume_pkg::ST_ERS_WAIT ||
                 state_q == suspend_resume_pkg::ST_PGM_WAIT) begin
      susp_cnt_q <= susp_cnt_q + 12'h001; // RULE_01 RULE_03
    end else begin
      susp_cnt_q <= 12'h000;
    end
  end

  // busy follows next state, low while suspended
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_d == suspend_resume_pkg::ST_ERASE) ||
                (state_d == suspend_resume_pkg::ST_ERS_WAIT) ||
                (state_d == suspend_resume_pkg::ST_PROGRAM) ||
                (state_d == suspend_resume_pkg::ST_PGM_WAIT); // RULE_14
    end
  end

  // parameter dword held in flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      param_dword12 <= `PRM_DWORD_RESET;
    end else begin
      param_dword12 <= {`PRM_SUSP_SUPPORTED, `PRM_ERS_LAT_UNITS, `PRM_ERS_LAT_COUNT,
                        `PRM_ERS_GAP_COUNT, `PRM_PGM_LAT_UNITS, `PRM_PGM_LAT_COUNT,
                        `PRM_PGM_GAP_COUNT, `PRM_RFU, `PRM_ERS_PROHIB,
                        `PRM_PGM_PROHIB}; // RULE_05
    end
  end

  // status outputs
  assign operation_busy_flag = busy_q;
  assign array_run = (state_q == suspend_resume_pkg::ST_ERASE) ||
                     (state_q == suspend_resume_pkg::ST_ERS_WAIT) ||
                     (state_q == suspend_resume_pkg::ST_PROGRAM) ||
                     (state_q == suspend_resume_pkg::ST_PGM_WAIT);
  assign erase_suspended = (state_q == suspend_resume_pkg::ST_ERS_SUSPENDED);
  assign program_suspended = (state_q == suspend_resume_pkg::ST_PGM_SUSPENDED);

  // ****************************************
  // checks
  // ****************************************
  a_erase_lat_bound: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_01
    (state_q == suspend_resume_pkg::ST_ERS_WAIT && susp_cnt_q == LAT_LAST && !op_complete)
    |=> state_q == suspend_resume_pkg::ST_ERS_SUSPENDED)
    else $error("erase suspend latency exceeded");

  a_program_lat_bound: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_03
    (state_q == suspend_resume_pkg::ST_PGM_WAIT && susp_cnt_q == LAT_LAST && !op_complete)
    |=> state_q == suspend_resume_pkg::ST_PGM_SUSPENDED)
    else $error("program suspend not reached in time");

  a_param_units: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_05
    param_dword12[`PRM_ERS_UNITS_POS+1:`PRM_ERS_UNITS_POS] == 2'b10 &&
    param_dword12[`PRM_PGM_UNITS_POS+1:`PRM_PGM_UNITS_POS] == 2'b10)
    else $error("latency units code wrong");

  a_erase_suspend_cmd: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_08
    (cmd_valid && cmd_op_q == 8'h75 && state_q == suspend_resume_pkg::ST_ERASE && !op_complete)
    |=> state_q == suspend_resume_pkg::ST_ERS_WAIT && busy_q)
    else $error("erase suspend not taken");

  a_erase_resume_cmd: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_09
    (cmd_valid && cmd_op_q == 8'h7a && erase_suspended)
    |=> state_q == suspend_resume_pkg::ST_ERASE && busy_q)
    else $error("erase resume not taken");

  a_program_suspend_cmd: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_10
    (cmd_valid && cmd_op_q == 8'h85 && state_q == suspend_resume_pkg::ST_PROGRAM && !op_complete)
    |=> state_q == suspend_resume_pkg::ST_PGM_WAIT)
    else $error("program suspend not taken");

  a_program_resume_cmd: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_11
    (cmd_valid && cmd_op_q == 8'h8a && program_suspended)
    |=> state_q == suspend_resume_pkg::ST_PROGRAM)
    else $error("program resume not taken");

  a_ignore_idle_cmd: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_13
    (cmd_valid && state_q == suspend_resume_pkg::ST_IDLE && !erase_start && !program_start)
    |=> state_q == suspend_resume_pkg::ST_IDLE && !busy_q)
    else $error("command acted on with nothing running");

  a_suspended_not_busy: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_14
    (erase_suspended || program_suspended) |-> !busy_q && !array_run)
    else $error("busy while suspended");

  c_erase_suspended: cover property (@(posedge core_clk) disable iff (!resetn)
    $rose(erase_suspended));
  c_program_suspended: cover property (@(posedge core_clk) disable iff (!resetn)
    $rose(program_suspended));
  c_erase_resumed: cover property (@(posedge core_clk) disable iff (!resetn)
    $fell(erase_suspended) ##1 state_q == suspend_resume_pkg::ST_ERASE);
  c_status_read: cover property (@(posedge sclk) disable iff (!resetn)
    $rose(rd_active_q));

endmodule // program_erase_suspend_resume

// ==== bench/serial_host_model.sv ====
// Purpose: host side of the serial link, sends one-byte commands and polls status
// Assumes: serial mode 0, msb first, 80 ns link period
// Notes: link clock runs only inside frames
`timescale 1ns/10ps

module serial_host_model (
  output logic sclk, // link clock, idle low
  output logic cs_n, // chip select, active low
  output logic si, // serial data to device
  input wire logic so, // serial data from device
  input wire logic so_oe // device drives so
);
  // idle link at time zero
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b1;
  end

  // one bit out before the rising edge, one bit in at it
  task automatic shift_bit(input logic b, output logic r);
    si = b;
    #40 sclk = 1'b1;
    r = so_oe ? so : 1'b1; // undriven line reads as pulled up
    #40 sclk = 1'b0;
  endtask

  // opcode, then nrd bytes read back; the last byte is returned
  task automatic frame(input logic [7:0] op, input int nrd, output logic [7:0] rd);
    logic r;
    #13 cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      shift_bit(op[i], r);
    end
    for (int n = 0; n < nrd; n++) begin
      for (int i = 7; i >= 0; i--) begin
        shift_bit(~si, r);
        rd[i] = r;
      end
    end
    #40 cs_n = 1'b1;
    si = ~si; // released line shows no stale level
  endtask
endmodule // serial_host_model

// ==== bench/testbench.sv ====
// Purpose: self-checking bench for suspend and resume control
// Assumes: core clock 10 ns, link clock 80 ns from the host model
// Notes: host keeps resume-to-suspend spacing except before the completion-while-pausing suspend, and starts nothing while suspended
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end

module testbench;
  logic core_clk, resetn, erase_start, program_start, op_complete, array_safe_pause;
  logic sclk, cs_n, si, so, so_oe, array_run, busy, ers_sus, pgm_sus;
  logic [31:0] param;
  logic [7:0] rd;
  int failures, cmp_count;

  // core clock
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  program_erase_suspend_resume dut_u (.core_clk(core_clk), .resetn(resetn), .sclk(sclk),
    .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .erase_start(erase_start),
    .program_start(program_start), .op_complete(op_complete),
    .array_safe_pause(array_safe_pause), .array_run(array_run),
    .operation_busy_flag(busy), .erase_suspended(ers_sus),
    .program_suspended(pgm_sus), .param_dword12(param));

  serial_host_model host_u (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

  // ****************************************
  // helpers
  // ****************************************
  task automatic wait_neg(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // send a suspend and count core cycles until busy drops
  task automatic suspend(input logic [7:0] op, input logic safe, output int n);
    @(posedge core_clk);
    array_safe_pause <= safe;
    host_u.frame(op, 0, rd);
    n = 0;
    while (busy !== 1'b0 && n < 4100) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  // full run: refusals, slow and fast suspend, resume, completion
  task automatic op_cycle(input bit pgm);
    logic [7:0] sus, res, other;
    int n;
    sus = pgm ? 8'h85 : 8'h75;
    res = pgm ? 8'h8a : 8'h7a;
    other = pgm ? 8'h75 : 8'h85;
    @(posedge core_clk);
    erase_start <= !pgm;
    program_start <= pgm;
    array_safe_pause <= 1'b1;
    @(posedge core_clk);
    erase_start <= 1'b0;
    program_start <= 1'b0;
    host_u.frame(8'h05, 2, rd);
    `CHK("status running", 8'h01, rd)
    host_u.frame(other, 0, rd);
    host_u.frame(res, 0, rd);
    wait_neg(20);
    `CHK("wrong command ignored", 3'b100, {busy, ers_sus, pgm_sus})
    suspend(sus, 1'b0, n);
    `CHK("slow suspend in time", 1'b1, n <= 4000)
    `CHK("suspended flags", {!pgm, pgm}, {ers_sus, pgm_sus})
    `CHK("array held", 1'b0, array_run)
    host_u.frame(8'h05, 2, rd);
    `CHK("status suspended", 8'h00, rd)
    host_u.frame(sus, 0, rd);
    host_u.frame(res, 0, rd);
    wait_neg(6);
    `CHK("busy resumed", 1'b1, busy)
    `CHK("flags cleared", 2'b00, {ers_sus, pgm_sus})
    wait_neg(12800); // host spacing before the next suspend
    suspend(sus, 1'b1, n);
    `CHK("fast suspend in time", 1'b1, n <= 4000)
    `CHK("suspended again", {!pgm, pgm}, {ers_sus, pgm_sus})
    host_u.frame(res, 0, rd); // nothing else started while suspended
    wait_neg(6);
    `CHK("run after resume", 1'b1, array_run)
    @(posedge core_clk);
    op_complete <= 1'b1;
    @(posedge core_clk);
    op_complete <= 1'b0;
    wait_neg(2);
    `CHK("idle after completion", 1'b0, busy)
    // completion while pausing ends the operation
    @(posedge core_clk);
    erase_start <= !pgm;
    program_start <= pgm;
    array_safe_pause <= 1'b0;
    @(posedge core_clk);
    erase_start <= 1'b0;
    program_start <= 1'b0;
    host_u.frame(sus, 0, rd);
    wait_neg(20);
    `CHK("pausing still busy", 2'b11, {busy, array_run})
    @(posedge core_clk);
    op_complete <= 1'b1;
    @(posedge core_clk);
    op_complete <= 1'b0;
    wait_neg(2);
    `CHK("completion while pausing", 4'b0000, {busy, array_run, ers_sus, pgm_sus})
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_idle();
    logic [7:0] ops [4] = '{8'h75, 8'h7a, 8'h85, 8'h8a};
    `CHK("param dword", 32'h441883ec, param)
    `CHK("latency units", 4'b1010, {param[30:29], param[19:18]})
    for (int i = 0; i < 4; i++) begin
      host_u.frame(ops[i], 0, rd);
      wait_neg(6);
      `CHK("idle command ignored", 3'b000, {busy, ers_sus, pgm_sus})
    end
    host_u.frame(8'h05, 1, rd);
    `CHK("status idle", 8'h00, rd)
    wait_neg(1);
    `CHK("so released", 1'b0, so_oe)
    $display("test idle done");
  endtask

  task automatic t_erase();
    op_cycle(1'b0);
    $display("test erase done");
  endtask

  task automatic t_program();
    op_cycle(1'b1);
    $display("test program done");
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog, well beyond the expected run
  initial begin
    repeat (90000) @(posedge core_clk);
    failures++;
    $display("[ERR] watchdog expected done seen hang");
    finish_test();
  end

  // main sequence
  initial begin
    resetn = 1'b0;
    erase_start = 1'b0;
    program_start = 1'b0;
    op_complete = 1'b0;
    array_safe_pause = 1'b0;
    failures = 0;
    cmp_count = 0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    t_idle();
    t_erase();
    t_program();
    finish_test();
  end
endmodule // testbench
